/* File: hw/dxio_pkg.sv */
// Package for the external I/O port block: map, fields, op codes, carriers
package dxio_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;
    localparam logic [7:0] REG_PC = 8'h18;
    localparam logic [7:0] REG_CPLATCH = 8'h1c;
    localparam logic [7:0] REG_INTDATA = 8'h20;
    // Control field positions
    localparam int CTRL_SERIAL = 0;
    localparam int CTRL_COPROC = 1;
    localparam int CTRL_FLAG = 2;
    // Status field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_TAKEN = 1;
    localparam int STAT_TEST = 2;
    // Port numbers of note
    localparam logic [2:0] PORT_INT_LAST = 3'h1;
    localparam logic [2:0] PORT_COPROC = 3'h5;
    // Reset values
    localparam logic [11:0] PC_RST = 12'h000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // Operation codes written to the command register
    localparam logic [2:0] OP_IN = 3'h0;
    localparam logic [2:0] OP_OUT = 3'h1;
    localparam logic [2:0] OP_TABLE_READ_OP = 3'h2;
    localparam logic [2:0] OP_TABLE_WRITE_OP = 3'h3;
    localparam logic [2:0] OP_BRANCH_ON_TEST_LOW = 3'h4;

    // Machine cycle of the running instruction
    typedef enum logic [1:0] {PH_IDLE, PH_C1, PH_C2, PH_C3} dxio_phase_t;

    // Pins driven toward the external bus
    typedef struct packed {
        logic [11:0] addr; // Address bus, port select in low three
        logic [15:0] data_out; // Data bus drive value
        logic data_oe; // Data bus drive enable
        logic data_read_strobe_n; // Port input strobe
        logic write_strobe_n; // Port output / table write strobe
        logic program_read_strobe_n; // Program memory read strobe
        logic external_flag_output; // Software flag pin
    } dxio_pins_t;

    // Whole state of the block
    typedef struct packed {
        dxio_phase_t ph; // Current machine cycle
        logic [2:0] op; // Running operation
        logic [2:0] ctrl; // Serial variant, coprocessor mode, flag
        logic [11:0] addr; // Port number, table address or branch target
        logic [15:0] wdata; // Outgoing word
        logic [15:0] intdata; // Internal port 0/1 word
        logic [15:0] rdata; // Captured incoming word
        logic [11:0] pc; // Program counter
        logic [2:0] cplatch; // Pending coprocessor pin values
        logic [2:0] cppins; // Coprocessor pin outputs
        logic taken; // Last branch test result
        logic tsync1; // Test input sync, first stage
        logic tsync2; // Test input sync, second stage
        logic bus_act; // AHB data phase pending
        logic bus_wr; // Pending phase is a write
        logic [7:0] bus_addr; // Pending byte address
        logic [31:0] hrdata; // Read data for the data phase
    } dxio_state_t;
endpackage

/* File: hw/dxio_port.sv */
// External I/O and table transfer port with AHB-Lite control registers
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Port in/out moves one word in two cycles
// - Port number shown on three lowest address lines, except in coprocessor mode (pins shown there)
// - Upper address lines zero during port instructions
// - Outside coprocessor mode, data bus driven only with write strobe, internal ports
// - Write strobe: output first cycle, table write second
// - Data read strobe only for port input
// - At most one strobe low at once
// - Table read uses program strobe; write uses write strobe
// - Dummy prefetch discarded, instruction fetched again after
// - Serial microcomputer pins show low counter bits otherwise
// - Reset clears port pins and program counter
// - Coprocessor pins change only on port five accesses
// - Coprocessor mode: bus driven only while host reads
// - Branch taken on test low, falls through high
// - Flag pin follows its control bit directly
// - Serial variant has no program read strobe
// - Eight ports each way; serial variant reads ports 0 and 1 internally, leaving six external inputs
// - Strobes held inactive high during reset
module dxio_port
(
    input wire logic hclk, // Bus clock, 20 MHz
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic hreadyout, // Always ready, no wait states
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data
    input wire logic [15:0] data_in, // External data bus level
    input wire logic branch_test_input, // Test pin, async
    input wire logic host_rd_n, // Host read strobe, coprocessor mode
    output dxio_pkg::dxio_pins_t pins // External bus outputs
);
    import dxio_pkg::*;

    dxio_state_t st_ff; // Registered state
    dxio_state_t nxt_st; // Next state
    logic busy; // Instruction running
    logic port_op; // Port in or out running
    logic int_port; // Serial variant input from port 0 or 1
    logic addr_ph; // AHB address phase accepted

    assign busy = (st_ff.ph != PH_IDLE);
    assign port_op = busy && (st_ff.op == OP_IN || st_ff.op == OP_OUT);
    assign int_port = st_ff.ctrl[CTRL_SERIAL] && busy && st_ff.op == OP_IN &&
        st_ff.addr[2:0] <= PORT_INT_LAST;
    assign addr_ph = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.hrdata;

    // Next-state: bus slave, sequencer, synchroniser
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tsync1 = branch_test_input;
        nxt_st.tsync2 = st_ff.tsync1;
        // Address phase: remember it and prepare read data
        nxt_st.bus_act = addr_ph;
        if (addr_ph)
        begin
            nxt_st.bus_wr = hwrite;
            nxt_st.bus_addr = haddr[7:0];
            unique case (haddr[7:0])
                REG_CTRL: nxt_st.hrdata = {29'h0, st_ff.ctrl};
                REG_ADDR: nxt_st.hrdata = {20'h0, st_ff.addr};
                REG_WDATA: nxt_st.hrdata = {16'h0, st_ff.wdata};
                REG_CMD: nxt_st.hrdata = {29'h0, st_ff.op};
                REG_STATUS: nxt_st.hrdata = {29'h0, st_ff.tsync2, st_ff.taken, busy};
                REG_RDATA: nxt_st.hrdata = {16'h0, st_ff.rdata};
                REG_PC: nxt_st.hrdata = {20'h0, st_ff.pc};
                REG_CPLATCH: nxt_st.hrdata = {26'h0, st_ff.cppins, st_ff.cplatch};
                REG_INTDATA: nxt_st.hrdata = {16'h0, st_ff.intdata};
                default: nxt_st.hrdata = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
        // Data phase of a write
        if (st_ff.bus_act && st_ff.bus_wr)
        begin
            unique case (st_ff.bus_addr)
                REG_CTRL: nxt_st.ctrl = hwdata[2:0];
                REG_ADDR: nxt_st.addr = hwdata[11:0];
                REG_WDATA: nxt_st.wdata = hwdata[15:0];
                REG_CMD:
                begin
                    // Commands while busy are dropped; poll the busy bit first
                    if (!busy)
                    begin
                        nxt_st.op = hwdata[2:0];
                        nxt_st.ph = PH_C1;
                    end
                end
                REG_PC: nxt_st.pc = hwdata[11:0];
                REG_CPLATCH: nxt_st.cplatch = hwdata[2:0];
                REG_INTDATA: nxt_st.intdata = hwdata[15:0];
                default: ; // Read-only or unmapped: ignored
            endcase
        end
        // Instruction sequencer
        unique case (st_ff.ph)
            PH_IDLE: ;
            PH_C1:
            begin
                if (st_ff.op == OP_BRANCH_ON_TEST_LOW)
                begin
                    // Branch on synchronised level only
                    nxt_st.taken = !st_ff.tsync2;
                    nxt_st.pc = st_ff.tsync2 ? st_ff.pc + 12'h001 : st_ff.addr;
                    nxt_st.ph = PH_IDLE;
                end
                else if (st_ff.op > OP_BRANCH_ON_TEST_LOW)
                begin
                    nxt_st.ph = PH_IDLE; // Unknown code: no bus activity
                end
                else
                begin
                    nxt_st.ph = PH_C2; // Port and table ops; for table ops C1 was dummy prefetch
                end
            end
            PH_C2:
            begin
                if (st_ff.op == OP_IN)
                begin
                    nxt_st.rdata = int_port ? st_ff.intdata : data_in;
                end
                if (st_ff.op == OP_TABLE_READ_OP)
                begin
                    // No program memory on serial variant: word reads zero
                    nxt_st.rdata = st_ff.ctrl[CTRL_SERIAL] ? DATA_RST : data_in;
                end
                if (st_ff.ctrl[CTRL_COPROC] && port_op && st_ff.addr[2:0] == PORT_COPROC)
                begin
                    nxt_st.cppins = st_ff.cplatch;
                end
                if (port_op)
                begin
                    nxt_st.pc = st_ff.pc + 12'h001;
                    nxt_st.ph = PH_IDLE;
                end
                else
                begin
                    nxt_st.ph = PH_C3;
                end
            end
            PH_C3:
            begin
                nxt_st.pc = st_ff.pc + 12'h001; // Refetch done
                nxt_st.ph = PH_IDLE;
            end
        endcase
    end

    // State register; reset clears pc and pins at once
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Pin drive from state
    always_comb
    begin
        pins.external_flag_output = st_ff.ctrl[CTRL_FLAG];
        pins.data_read_strobe_n = !(port_op && st_ff.op == OP_IN);
        pins.write_strobe_n = !((st_ff.ph == PH_C1 && st_ff.op == OP_OUT) ||
            (st_ff.ph == PH_C2 && st_ff.op == OP_TABLE_WRITE_OP));
        // Program strobe in all three table read cycles, table write first and third only, absent on serial variant
        pins.program_read_strobe_n = !(busy && !st_ff.ctrl[CTRL_SERIAL] &&
            (st_ff.op == OP_TABLE_READ_OP || (st_ff.op == OP_TABLE_WRITE_OP && st_ff.ph != PH_C2)));
        pins.data_out = int_port ? st_ff.intdata : st_ff.wdata;
        if (st_ff.ctrl[CTRL_COPROC])
        begin
            pins.data_oe = !host_rd_n;
            pins.addr = {9'h000, st_ff.cppins};
        end
        else
        begin
            pins.data_oe = !pins.write_strobe_n || int_port;
            if (port_op)
            begin
                pins.addr = {9'h000, st_ff.addr[2:0]};
            end
            else if (st_ff.ctrl[CTRL_SERIAL])
            begin
                pins.addr = {9'h000, st_ff.pc[2:0]};
            end
            else if (busy && st_ff.ph == PH_C2 && st_ff.op != OP_BRANCH_ON_TEST_LOW)
            begin
                pins.addr = st_ff.addr; // Table address
            end
            else if (busy && st_ff.op != OP_BRANCH_ON_TEST_LOW)
            begin
                pins.addr = st_ff.pc + 12'h001; // Prefetch of next
            end
            else
            begin
                pins.addr = st_ff.pc;
            end
        end
    end

    // Checks on the external bus behaviour
    AST_IN_TWO: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.ph == PH_C1 && st_ff.op == OP_IN) |=> st_ff.ph == PH_C2 ##1 st_ff.ph == PH_IDLE)
        else $error("Port input not two cycles");
    AST_PORT_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
        (port_op && !st_ff.ctrl[CTRL_COPROC]) |-> pins.addr[2:0] == st_ff.addr[2:0])
        else $error("Port number missing on low lines");
    AST_HIGH_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        (port_op && !st_ff.ctrl[CTRL_COPROC]) |-> pins.addr[11:3] == 9'h000)
        else $error("Upper address not zero in port op");
    AST_BUS_HIZ: assert property (@(posedge hclk) disable iff (!hresetn)
        (pins.data_oe && !st_ff.ctrl[CTRL_COPROC]) |-> (!pins.write_strobe_n || int_port))
        else $error("Data bus driven outside write");
    AST_WE_WHEN: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.ph == PH_C1 && st_ff.op == OP_OUT) |-> !pins.write_strobe_n ##1
        pins.write_strobe_n)
        else $error("Output write strobe misplaced");
    AST_TABLE_WRITE_OP_WE: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.ph == PH_C1 && st_ff.op == OP_TABLE_WRITE_OP) |-> pins.write_strobe_n ##1
        !pins.write_strobe_n ##1 pins.write_strobe_n)
        else $error("Table write strobe not in second cycle");
    AST_DEN_ONLY_IN: assert property (@(posedge hclk) disable iff (!hresetn)
        !pins.data_read_strobe_n |-> (busy && st_ff.op == OP_IN))
        else $error("Data read strobe outside port input");
    AST_EXCL: assert property (@(posedge hclk) disable iff (!hresetn)
        $onehot0({!pins.data_read_strobe_n, !pins.write_strobe_n, !pins.program_read_strobe_n}))
        else $error("Strobes overlap");
    AST_TABLE_READ_OP_MEN: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.ph == PH_C1 && st_ff.op == OP_TABLE_READ_OP && !st_ff.ctrl[CTRL_SERIAL]) |->
        (!pins.program_read_strobe_n) [*3] ##1 st_ff.ph == PH_IDLE)
        else $error("Table read strobes wrong");
    AST_REFETCH: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.ph == PH_C3 && !st_ff.ctrl[CTRL_COPROC] && !st_ff.ctrl[CTRL_SERIAL]) |->
        pins.addr == st_ff.pc + 12'h001)
        else $error("Refetch address wrong");
    AST_PC_SHOW: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.ctrl[CTRL_SERIAL] && !st_ff.ctrl[CTRL_COPROC] && !port_op) |->
        pins.addr == {9'h000, st_ff.pc[2:0]})
        else $error("Counter bits not on port pins");
    AST_CP_STABLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !$stable(st_ff.cppins) |-> $past(port_op && st_ff.ph == PH_C2 &&
        st_ff.addr[2:0] == PORT_COPROC && st_ff.ctrl[CTRL_COPROC]))
        else $error("Coprocessor pins changed outside port five");
    AST_CP_HIZ: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.ctrl[CTRL_COPROC] |-> (pins.data_oe == !host_rd_n))
        else $error("Coprocessor bus drive wrong");
    AST_BRANCH: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.ph == PH_C1 && st_ff.op == OP_BRANCH_ON_TEST_LOW) |=>
        st_ff.pc == ($past(st_ff.tsync2) ? $past(st_ff.pc) + 12'h001 : $past(st_ff.addr)))
        else $error("Branch test result wrong");
    AST_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        pins.external_flag_output == st_ff.ctrl[CTRL_FLAG])
        else $error("Flag pin not following bit");
    AST_NO_MEN: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.ctrl[CTRL_SERIAL] |-> pins.program_read_strobe_n)
        else $error("Program strobe on serial variant");
    AST_RESET_OUT: assert property (@(posedge hclk)
        !hresetn |-> (pins.write_strobe_n && pins.data_read_strobe_n &&
        pins.program_read_strobe_n && st_ff.pc == PC_RST))
        else $error("Reset state wrong");

    COV_IN: cover property (@(posedge hclk) disable iff (!hresetn)
        st_ff.ph == PH_C2 && st_ff.op == OP_IN);
    COV_OUT: cover property (@(posedge hclk) disable iff (!hresetn)
        !pins.write_strobe_n && st_ff.op == OP_OUT);
    COV_TABLE_READ_OP: cover property (@(posedge hclk) disable iff (!hresetn)
        st_ff.ph == PH_C3 && st_ff.op == OP_TABLE_READ_OP);
    COV_TABLE_WRITE_OP: cover property (@(posedge hclk) disable iff (!hresetn)
        !pins.write_strobe_n && st_ff.op == OP_TABLE_WRITE_OP);
    COV_TAKEN: cover property (@(posedge hclk) disable iff (!hresetn)
        st_ff.ph == PH_C1 && st_ff.op == OP_BRANCH_ON_TEST_LOW && !st_ff.tsync2);
endmodule

/* File: bench/dxio_periph.sv */
// Behavioural peripherals and external program memory on the far side of the port
`timescale 1ns/1ps
module dxio_periph
(
    input wire logic hclk, // Processor clock
    input wire dxio_pkg::dxio_pins_t pins, // Outputs of the port
    input wire logic quiet01, // Serial variant: ports 0 and 1 are internal
    output logic [15:0] bus, // Resolved data bus level
    output logic [11:0] wr_addr, // Address at last write strobe
    output logic [15:0] wr_data // Bus level at last write strobe
);
    import dxio_pkg::*;
    logic [15:0] last_ff = 16'h0000; // Last bus level; known start so the flip is never unknown
    // Bus resolution; a released bus never shows the stale word
    always_comb
    begin
        if (pins.data_oe)
            bus = pins.data_out;
        else if (!pins.data_read_strobe_n && !(quiet01 && pins.addr[2:0] < 3'h2))
            bus = 16'hc000 | {13'h0, pins.addr[2:0]};
        else if (!pins.program_read_strobe_n) // Program memory answers
            bus = 16'h5000 ^ {4'h0, pins.addr};
        else // Nobody drives: flip every cycle
            bus = ~last_ff;
    end
    // Latch writes, whether aimed at a port or at program memory
    always_ff @(posedge hclk)
    begin
        last_ff <= bus;
        if (!pins.write_strobe_n)
        begin
            wr_addr <= pins.addr;
            wr_data <= bus;
        end
    end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the external I/O port block
`timescale 1ns/1ps
module testbench;
    import dxio_pkg::*;
    logic hclk = 1'b0; // Bus clock
    logic hresetn = 1'b1; // Reset, active low; pulled low at time zero for a real edge
    logic hsel = 1'b0; // Slave select
    logic [31:0] haddr = 32'h0; // Byte address
    logic [1:0] htrans = 2'h0; // Transfer type
    logic hwrite = 1'b0; // Direction
    logic [2:0] hsize = 3'h2; // Word transfers only
    logic [31:0] hwdata = 32'h0; // Write data
    logic hreadyout; // Slave ready
    logic hresp; // Slave response
    logic [31:0] hrdata; // Read data
    logic [15:0] bus; // Resolved data bus
    logic branch_test_input = 1'b1; // Test pin
    logic host_rd_n = 1'b1; // Host read strobe
    dxio_pins_t pins; // Port outputs
    logic [11:0] wr_addr; // Last written address
    logic [15:0] wr_data; // Last written data
    int n_fail = 0; // Mismatches
    int n_checks = 0; // Comparisons
    int n_den, n_we, n_men, n_oe, we_pos; // Per-operation strobe tally
    logic [11:0] men_a [0:3]; // Addresses under program strobe
    logic [2:0] mode = 3'h0; // Control value in force
    logic [31:0] rd, pc, ta, wd; // Scratch
    int p; // Port number

    always #25 hclk = ~hclk; // 20 MHz

    dxio_port dut_u
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .data_in(bus),
        .branch_test_input(branch_test_input), .host_rd_n(host_rd_n), .pins(pins)
    );
    dxio_periph far_u
    (
        .hclk(hclk), .pins(pins), .quiet01(mode[CTRL_SERIAL]), .bus(bus),
        .wr_addr(wr_addr), .wr_data(wr_data)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One AHB-Lite single word transfer; waits on the slave's ready
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, rd);
    endtask

    // Start an operation and poll until it is no longer busy
    task automatic run_op(input logic [2:0] op);
        n_den = 0;
        n_we = 0;
        n_men = 0;
        n_oe = 0;
        we_pos = 0;
        wreg(REG_CMD, {29'h0, op});
        rd = 32'h1;
        for (int i = 0; i < 8 && rd[STAT_BUSY]; i++)
            ahb(1'b0, REG_STATUS, 32'h0, rd);
        check("busy cleared", 0, rd[STAT_BUSY]);
    endtask

    function automatic int tally();
        return we_pos * 65536 + n_oe * 4096 + n_den * 256 + n_we * 16 + n_men;
    endfunction

    // Per-cycle watcher on the settled pins
    always @(negedge hclk)
    begin
        if (hresetn)
        begin
            check("one strobe", 1, $countones(~{pins.data_read_strobe_n, pins.write_strobe_n,
                  pins.program_read_strobe_n}) < 2);
            if (mode == 3'h0 && !pins.data_read_strobe_n)
                check("upper addr", 0, pins.addr[11:3]);
            if (mode == 3'h0)
                check("bus drive", !pins.write_strobe_n, pins.data_oe);
            if (!pins.write_strobe_n)
                we_pos = n_men;
            if (!pins.program_read_strobe_n && n_men < 4)
                men_a[n_men] = pins.addr;
            n_den += !pins.data_read_strobe_n;
            n_we += !pins.write_strobe_n;
            n_men += !pins.program_read_strobe_n;
            n_oe += pins.data_oe;
        end
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial
    begin
        #(20000 * 50);
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        hresetn <= 1'b0;
        rd = $urandom(38);
        repeat (3) @(posedge hclk);
        check("reset strobes", 3'h7, {pins.data_read_strobe_n, pins.write_strobe_n,
              pins.program_read_strobe_n});
        check("reset addr", 0, {pins.data_oe, pins.addr});
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // Every port both ways, random data
        for (p = 0; p < 8; p++)
        begin
            wd = $urandom_range(0, 16'hffff);
            wreg(REG_ADDR, p);
            wreg(REG_WDATA, wd);
            ahb(1'b0, REG_PC, 32'h0, pc);
            run_op(OP_OUT);
            check("out data", wd, wr_data);
            check("out port", p, wr_addr);
            check("out strobes", 32'h01010, tally());
            run_op(OP_IN);
            check("in strobes", 32'h00200, tally());
            ahb(1'b0, REG_RDATA, 32'h0, rd);
            check("in data", 16'hc000 | p, rd);
            ahb(1'b0, REG_PC, 32'h0, rd);
            check("pc step", (pc + 2) & 12'hfff, rd);
        end
        // Table transfers at addresses clear of the port area
        for (int k = 0; k < 4; k++)
        begin
            ta = 12'h008 + $urandom_range(0, 12'hff7);
            wd = $urandom_range(0, 16'hffff);
            wreg(REG_ADDR, ta);
            wreg(REG_WDATA, wd);
            ahb(1'b0, REG_PC, 32'h0, pc);
            run_op(OP_TABLE_READ_OP);
            check("table_read_op strobes", 32'h00003, tally());
            check("dummy fetch", (pc + 1) & 12'hfff, men_a[0]);
            check("table addr", ta, men_a[1]);
            check("refetch", (pc + 1) & 12'hfff, men_a[2]);
            ahb(1'b0, REG_RDATA, 32'h0, rd);
            check("table_read_op data", 16'h5000 ^ ta, rd);
            run_op(OP_TABLE_WRITE_OP);
            check("table_write_op strobes", 32'h11012, tally());
            check("table_write_op data", wd, wr_data);
            check("table_write_op addr", ta, wr_addr);
        end
        // Branch on test low, then high
        for (int t = 0; t < 2; t++)
        begin
            branch_test_input <= t[0];
            ta = $urandom_range(0, 12'hfff);
            wreg(REG_ADDR, ta);
            ahb(1'b0, REG_PC, 32'h0, pc);
            run_op(OP_BRANCH_ON_TEST_LOW);
            ahb(1'b0, REG_PC, 32'h0, rd);
            check("branch pc", t ? (pc + 1) & 12'hfff : ta, rd);
            ahb(1'b0, REG_STATUS, 32'h0, rd);
            check("taken", t == 0, rd[STAT_TAKEN]);
        end
        // Flag pin both ways
        for (int f = 1; f >= 0; f--)
        begin
            wreg(REG_CTRL, f << CTRL_FLAG);
            @(negedge hclk);
            check("flag", f, pins.external_flag_output);
        end
        // Serial variant, microcomputer mode
        wreg(REG_CTRL, 32'h1);
        mode = 3'h1;
        wreg(REG_PC, 32'h5a3);
        @(negedge hclk);
        check("idle pins", 12'h003, pins.addr);
        wd = $urandom_range(0, 16'hffff);
        wreg(REG_INTDATA, wd);
        wreg(REG_ADDR, 32'h1);
        run_op(OP_IN);
        check("internal in", 32'h02200, tally());
        ahb(1'b0, REG_RDATA, 32'h0, rd);
        check("internal data", wd, rd);
        run_op(OP_TABLE_READ_OP);
        check("no prog strobe", 32'h0, tally());
        // Coprocessor mode
        wreg(REG_CTRL, 32'h2);
        mode = 3'h2;
        wreg(REG_CPLATCH, 32'h5);
        wreg(REG_ADDR, 32'h3);
        run_op(OP_OUT);
        @(negedge hclk);
        check("cp pins held", 0, pins.addr);
        wreg(REG_ADDR, PORT_COPROC);
        run_op(OP_OUT);
        @(negedge hclk);
        check("cp pins load", 5, pins.addr);
        for (int h = 0; h < 2; h++)
        begin
            @(posedge hclk);
            host_rd_n <= h[0];
            @(negedge hclk);
            check("cp drive", h == 0, pins.data_oe);
        end
        // Unmapped place reads zero, ignores writes
        wreg(8'h40, 32'hffffffff);
        ahb(1'b0, 8'h40, 32'h0, rd);
        check("unmapped", 0, rd);
        tally_and_finish();
    end
endmodule
